// ==== hw/pinirq_top.sv ====
// Eight-pin external interrupt unit with register port and shared flag
//
// How it works
// R1: Eight input pins each feed one shared detection flag.
// R2: In wait mode everything runs; enabled flag with enable raises the request.
// R3: In light stop the synchronised pins are watched on mclk; wake asserts if enabled.
// R4: Deep stop disables the unit; leaving it restores the control, enable, polarity and flag reset values.
// R5: Background debug halt does not stop detection or flagging.
// R6: Status bits 7:4 always read zero.
// R7: Status bit 3 is the read-only flag; writes leave it alone.
// R8: Status bit 2 is write-one acknowledge and always reads zero.
// R9: Status bit 1 enables the interrupt request output.
// R10: Status bit 0 picks edges only (0) or edges and levels (1).
// R11: Enable mask bit 1 makes its pin a source; disabled pins never count.
// R12: Polarity bit 0 means falling or low, 1 rising or high.
// R13: Edges are found on mclk: deasserted one cycle, asserted the next.
// R14: The source must idle deasserted before an edge can be seen.
// R15: Edge mode: edge sets flag, acknowledge clears it unless an edge arrives in the same cycle.
// R16: Level mode: acknowledge clears only if every enabled pin is deasserted.
// R17: Enabled resistor pulls up for polarity 0, down for polarity 1.
// R18: Software masks, sets polarity, resistors, enables, acknowledges, then unmasks.
// R19: Control bits, enables, polarities and flag reset to zero.
// R20: Request stays high while flag and interrupt enable are both set.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "pinirq_defines.svh"
module pinirq_top
    import pinirq_pkg::*;
#(
    parameter int NPINS = 8
) (
    // Clock, reset, clock enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Power state from the system
    input wire logic wait_mode,
    input wire logic bdm_halt,
    input wire logic [1:0] power_mode,
    // Pins and pad controls
    input wire logic [NPINS-1:0] pin_interrupt_input,
    input wire logic [NPINS-1:0] port_resistor_enable,
    output logic [NPINS-1:0] pad_pullup,
    output logic [NPINS-1:0] pad_pulldown,
    // Interrupt and wake
    output logic irq_req,
    output logic wake_req
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pinirq_req_s req;
    pinirq_cfg_s cfg;
    pinirq_pmode_e pmode;
    logic [7:0] enable_r, enable_nxt;
    logic [7:0] polarity_r, polarity_nxt;
    logic irq_request_enable_r, irq_request_enable_nxt;
    logic level_sense_r, level_sense_nxt;
    logic detect_flag_r, detect_flag_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic wake_r, wake_nxt;
    logic [NPINS-1:0] pu_r, pu_nxt;
    logic [NPINS-1:0] pd_r, pd_nxt;
    logic deep_r, deep_nxt;
    logic [NPINS-1:0] edge_hit;
    logic [NPINS-1:0] asserted;
    logic [NPINS-1:0] lstop_act;
    logic ack_write;
    logic set_flag;
    logic leave_deep;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign pmode = pinirq_pmode_e'(power_mode);
    assign cfg = '{enable: enable_r, polarity: polarity_r, level_mode: level_sense_r};

    // Status byte assembled once, used by the read mux
    function automatic logic [7:0] status_byte(input logic flag, input logic ien, input logic lvl);
        logic [7:0] b;
        b = `PINIRQ_RST_BYTE; // see R6
        b[`PINIRQ_SC_FLAG_BIT] = flag; // see R7
        b[`PINIRQ_SC_IRQEN_BIT] = ien;
        b[`PINIRQ_SC_LEVEL_BIT] = lvl;
        return b; // acknowledge bit stays 0, see R8
    endfunction

    // ------------------------------------------------------------------
    // Detector: synchronised pins, edges and asserted levels
    // ------------------------------------------------------------------
    pinirq_detect #(
        .NPINS(NPINS)
    ) u_detect (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .clear_state(leave_deep),
        .pins(pin_interrupt_input),
        .enable(cfg.enable[NPINS-1:0]),
        .polarity(cfg.polarity[NPINS-1:0]),
        .edge_hit(edge_hit),
        .asserted(asserted)
    );

    // Light stop: asserted enabled pins, taken after the synchroniser so no
    // raw pin reaches logic; the wake flop looks at them, as the flag does in level mode.
    assign lstop_act = asserted; // see R3

    // Edge always sets; level mode also sets on any asserted enabled pin
    assign set_flag = (|edge_hit) | (cfg.level_mode & (|asserted)); // see R1, R10, R15, R16
    assign ack_write = req.wr && req.addr == `PINIRQ_OFS_STATUS_CONTROL && req.wdata[`PINIRQ_SC_ACK_BIT];
    assign leave_deep = deep_r && pmode != PINIRQ_DEEP_STOP;

    // ------------------------------------------------------------------
    // Next-state logic for registers, flag and outputs
    // ------------------------------------------------------------------
    always_comb begin
        enable_nxt = enable_r;
        polarity_nxt = polarity_r;
        irq_request_enable_nxt = irq_request_enable_r;
        level_sense_nxt = level_sense_r;
        detect_flag_nxt = detect_flag_r;
        rdata_nxt = `PINIRQ_RST_BYTE;
        deep_nxt = (pmode == PINIRQ_DEEP_STOP);
        // Register writes; flag bit itself ignores writes
        if (req.wr) begin
            case (req.addr)
                `PINIRQ_OFS_STATUS_CONTROL: begin
                    irq_request_enable_nxt = req.wdata[`PINIRQ_SC_IRQEN_BIT]; // see R9
                    level_sense_nxt = req.wdata[`PINIRQ_SC_LEVEL_BIT]; // see R10
                end
                `PINIRQ_OFS_ENABLE_MASK: enable_nxt = req.wdata; // see R11
                `PINIRQ_OFS_POLARITY_SELECT: polarity_nxt = req.wdata; // see R12
                default: ;
            endcase
        end
        // Acknowledge clears; set wins, so in level mode an asserted pin keeps it
        if (ack_write) begin
            detect_flag_nxt = 1'b0; // see R15
        end
        if (set_flag) begin
            detect_flag_nxt = 1'b1; // see R16
        end
        // Read data valid the cycle after the strobe only
        if (req.rd) begin
            case (req.addr)
                `PINIRQ_OFS_STATUS_CONTROL: rdata_nxt = status_byte(detect_flag_r, irq_request_enable_r, level_sense_r);
                `PINIRQ_OFS_ENABLE_MASK: rdata_nxt = enable_r;
                `PINIRQ_OFS_POLARITY_SELECT: rdata_nxt = polarity_r;
                `PINIRQ_OFS_POWER_MODE: rdata_nxt = {6'h00, power_mode};
                default: rdata_nxt = `PINIRQ_RST_BYTE;
            endcase
        end
        // Deep stop: unit held disabled and reset on the way out
        if (pmode == PINIRQ_DEEP_STOP || leave_deep) begin
            enable_nxt = `PINIRQ_RST_BYTE; // see R4
            polarity_nxt = `PINIRQ_RST_BYTE;
            irq_request_enable_nxt = 1'b0;
            level_sense_nxt = 1'b0;
            detect_flag_nxt = 1'b0;
        end
    end

    // Output next values; wait and debug halt change nothing here
    always_comb begin
        irq_nxt = detect_flag_nxt & irq_request_enable_nxt; // see R2, R5, R9, R20
        wake_nxt = irq_nxt;
        if (pmode == PINIRQ_LIGHT_STOP && irq_request_enable_nxt) begin
            wake_nxt = irq_nxt | (|lstop_act); // see R3
        end
        pu_nxt = port_resistor_enable & ~polarity_nxt[NPINS-1:0]; // see R17
        pd_nxt = port_resistor_enable & polarity_nxt[NPINS-1:0];
    end

    // Register stage for everything above; wait_mode and bdm_halt gate nothing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable_r <= `PINIRQ_RST_BYTE; // see R19
            polarity_r <= `PINIRQ_RST_BYTE;
            irq_request_enable_r <= 1'b0;
            level_sense_r <= 1'b0;
            detect_flag_r <= 1'b0;
            rdata_r <= `PINIRQ_RST_BYTE;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            pu_r <= '0;
            pd_r <= '0;
            deep_r <= 1'b0;
        end else if (clk_en) begin
            enable_r <= enable_nxt;
            polarity_r <= polarity_nxt;
            irq_request_enable_r <= irq_request_enable_nxt;
            level_sense_r <= level_sense_nxt;
            detect_flag_r <= detect_flag_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            wake_r <= wake_nxt;
            pu_r <= pu_nxt;
            pd_r <= pd_nxt;
            deep_r <= deep_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq_req = irq_r;
    assign wake_req = wake_r;
    assign pad_pullup = pu_r;
    assign pad_pulldown = pd_r;

endmodule

// ==== hw/pinirq_defines.svh ====
// Register offsets, field positions and reset values of the pin interrupt unit
`ifndef PINIRQ_DEFINES_SVH
`define PINIRQ_DEFINES_SVH

// ------------------------------------------------------------------
// Register offsets (index on the plain register port)
// ------------------------------------------------------------------
`define PINIRQ_OFS_STATUS_CONTROL 2'h0
`define PINIRQ_OFS_ENABLE_MASK 2'h1
`define PINIRQ_OFS_POLARITY_SELECT 2'h2
`define PINIRQ_OFS_POWER_MODE 2'h3

// ------------------------------------------------------------------
// Status and control field positions
// ------------------------------------------------------------------
`define PINIRQ_SC_FLAG_BIT 3
`define PINIRQ_SC_ACK_BIT 2
`define PINIRQ_SC_IRQEN_BIT 1
`define PINIRQ_SC_LEVEL_BIT 0

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PINIRQ_RST_BYTE 8'h00
`define PINIRQ_PIN_IDLE 1'h0

`endif

// ==== hw/pinirq_pkg.sv ====
// Types shared by the pin interrupt unit files
package pinirq_pkg;

    // ------------------------------------------------------------------
    // Power modes seen by the unit
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PINIRQ_RUN,
        PINIRQ_LIGHT_STOP,
        PINIRQ_DEEP_STOP
    } pinirq_pmode_e;

    // ------------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pinirq_req_s;

    // Software configuration handed to the detector
    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] polarity;
        logic level_mode;
    } pinirq_cfg_s;

endpackage

// ==== hw/pinirq_detect.sv ====
// Per-pin synchroniser, edge and level detector of the pin interrupt unit
`include "pinirq_defines.svh"
module pinirq_detect
    import pinirq_pkg::*;
#(
    parameter int NPINS = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic clear_state,
    // Pins and setup
    input wire logic [NPINS-1:0] pins,
    input wire logic [NPINS-1:0] enable,
    input wire logic [NPINS-1:0] polarity,
    // Results
    output logic [NPINS-1:0] edge_hit,
    output logic [NPINS-1:0] asserted
);

    logic [NPINS-1:0] sync1_r, sync1_nxt;
    logic [NPINS-1:0] sync2_r, sync2_nxt;
    logic [NPINS-1:0] prev_r, prev_nxt;

    // ------------------------------------------------------------------
    // Per pin: active-level view and edge between two bus cycles
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            logic act_now;
            logic act_prev;
            // Polarity 0 means active low, 1 active high
            assign act_now = sync2_r[g] ~^ polarity[g]; // see R12
            assign act_prev = prev_r[g] ~^ polarity[g];
            // Deasserted one cycle then asserted the next
            assign edge_hit[g] = enable[g] & act_now & ~act_prev; // see R13
            assign asserted[g] = enable[g] & act_now; // see R11
        end
    endgenerate

    // Next values: pins pass two flops before any logic looks at them
    always_comb begin
        sync1_nxt = pins;
        sync2_nxt = sync1_r;
        prev_nxt = sync2_r;
        if (clear_state) begin
            // Deep stop wake: previous sample forgotten, no false edge kept
            prev_nxt = {NPINS{`PINIRQ_PIN_IDLE}};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else if (clk_en) begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
        end
    end

endmodule

// ==== tb/kpi_asserts.sv ====
// Port checker of the pin interrupt unit
module kpi_asserts #(parameter int NPINS = 8) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and requests
    input wire logic [1:0] power_mode,
    input wire logic [NPINS-1:0] pin_interrupt_input,
    input wire logic [NPINS-1:0] port_resistor_enable,
    input wire logic [NPINS-1:0] pad_pullup,
    input wire logic irq_req,
    input wire logic wake_req
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // Mirrors
    // ----------
    logic [NPINS-1:0] en_m, pol_m, pin_q;
    logic ie_m, lvl_m, rd_v;
    logic [1:0] rd_a;
    logic [2:0] quiet;
    // Software view; deep stop wipes it as it wipes the unit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst || power_mode == 2'h2) begin
            {ie_m, lvl_m, en_m, pol_m} <= '0;
        end else if (reg_wr) begin
            if (reg_addr == 2'h0) {ie_m, lvl_m} <= reg_wdata[1:0];
            if (reg_addr == 2'h1) en_m <= reg_wdata[NPINS-1:0];
            if (reg_addr == 2'h2) pol_m <= reg_wdata[NPINS-1:0];
        end
    end
    // Quiet pins for seven cycles mean no edge is still in the synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {pin_q, quiet, rd_v, rd_a} <= '0;
        end else begin
            pin_q <= pin_interrupt_input;
            quiet <= (pin_q != pin_interrupt_input) ? 3'h0 : (quiet == 3'h7 ? 3'h7 : quiet + 3'h1);
            rd_v <= reg_rd;
            rd_a <= reg_addr;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_sc_spare: assert property (rd_v && rd_a == 2'h0 |-> reg_rdata[7:4] == 4'h0)
        else $error("status spare bits set");
    chk_ack_zero: assert property (rd_v && rd_a == 2'h0 |-> !reg_rdata[2])
        else $error("acknowledge bit read as one");
    chk_sc_ctrl: assert property (rd_v && rd_a == 2'h0 |-> reg_rdata[1:0] == $past({ie_m, lvl_m}))
        else $error("control bits read wrong");
    chk_mask_read: assert property (rd_v && rd_a == 2'h1 |-> reg_rdata[NPINS-1:0] == $past(en_m))
        else $error("enable mask read wrong");
    chk_pol_read: assert property (rd_v && rd_a == 2'h2 |-> reg_rdata[NPINS-1:0] == $past(pol_m))
        else $error("polarity read wrong");
    chk_irq_gate: assert property (irq_req |-> ie_m)
        else $error("request without enable");
    chk_wake_irq: assert property (irq_req |-> wake_req)
        else $error("request without wake");
    chk_pull_dir: assert property (power_mode != 2'h2 && $past(power_mode) != 2'h2 && $stable(port_resistor_enable)
        && $stable(pol_m) |-> pad_pullup == (port_resistor_enable & ~pol_m))
        else $error("pullup select wrong");
    chk_ack_clear: assert property (reg_wr && reg_addr == 2'h0 && reg_wdata[2:1] == 2'h3 && !lvl_m
        && quiet == 3'h7 |=> !irq_req)
        else $error("acknowledge did not clear");
    chk_level_keep: assert property (reg_wr && reg_addr == 2'h0 && reg_wdata[2:0] == 3'h7 && lvl_m && quiet == 3'h7
        && |(en_m & ~(pin_interrupt_input ^ pol_m)) |=> irq_req)
        else $error("flag cleared with pin asserted");
endmodule

// ==== tb/kpi_keypad.sv ====
// Keypad model driving the interrupt pins
module kpi_keypad #(parameter int LAG_NS = 1) (
    // Keys and polarity
    input wire logic [7:0] press,
    input wire logic [7:0] pol,
    // Pins
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released keys rest inactive, so every press is a clean edge
    assign #(LAG_NS) pins = ~(press ^ pol);
endmodule

// ==== tb/tb_keyboard_pin_interrupt.sv ====
// Self-checking bench of the pin interrupt unit
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_keyboard_pin_interrupt;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wait_mode = 1'b0, bdm_halt = 1'b0;
    logic [1:0] reg_addr = 2'h0, power_mode = 2'h0;
    logic [7:0] reg_wdata = 8'h00, press = 8'h00, pol_t = 8'h00, res_en = 8'h00, m_en = 8'h00, m_pol = 8'h00;
    logic [7:0] reg_rdata, pins, pad_pu, pad_pd, v;
    logic irq_req, wake_req;
    int n_mismatch = 0, samples_checked = 0, m_ie = 0, m_lvl = 0, m_flag = 0, k;
    pinirq_top uut (.mclk(mclk), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_mode(wait_mode), .bdm_halt(bdm_halt),
        .power_mode(power_mode), .pin_interrupt_input(pins), .port_resistor_enable(res_en), .pad_pullup(pad_pu),
        .pad_pulldown(pad_pd), .irq_req(irq_req), .wake_req(wake_req));
    kpi_keypad u_keys (.press(press), .pol(pol_t), .pins(pins));
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // Wait and debug halt wander; detection must not care
    always @(posedge mclk) begin
        wait_mode <= 1'($urandom);
        bdm_halt <= 1'($urandom);
    end
    // ----------
    // Bus tasks
    // ----------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge mclk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // Compares status, mask and polarity registers, the request and the pads with the model
    task automatic chk_all();
        rd(2'h0);
        `CHK("status", {4'h0, m_flag[0], 1'b0, m_ie[0], m_lvl[0]}, v)
        `CHK("irq", 1'(m_flag & m_ie), irq_req)
        rd(2'h1);
        `CHK("mask", m_en, v)
        rd(2'h2);
        `CHK("polarity", m_pol, v)
        `CHK("pads", {res_en & ~m_pol, res_en & m_pol}, {pad_pu, pad_pd})
    endtask
    // Safe bring-up order, so enabling pins leaves no stale flag
    task automatic cfg(input logic [7:0] en, input logic [7:0] pl, input int lv);
        wr(2'h0, 8'(lv));
        wr(2'h1, 8'h00);
        wr(2'h2, pl);
        pol_t <= pl;
        repeat (4) @(posedge mclk);
        wr(2'h1, en);
        repeat (4) @(posedge mclk);
        wr(2'h0, 8'h04 | 8'(lv));
        wr(2'h0, 8'h02 | 8'(lv));
        {m_en, m_pol} = {en, pl};
        m_lvl = lv;
        m_flag = 0;
        m_ie = 1;
    endtask
    // Moves one key, then lets the synchroniser and flag settle
    task automatic key(input int kk, input logic on);
        press[kk] <= on;
        repeat (8) @(posedge mclk);
        if (on && m_en[kk]) m_flag = 1;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(29955));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        chk_all();
        wr(2'h2, 8'ha5);
        wr(2'h3, 8'hff);
        wr(2'h0, 8'hff);
        m_pol = 8'ha5;
        m_ie = 1;
        m_lvl = 1;
        chk_all();
        $display("test registers done");
        repeat (12) begin
            res_en <= 8'($urandom);
            k = $urandom % 8;
            cfg(8'($urandom), 8'($urandom), 0);
            key(k, 1);
            wr(2'h0, 8'h02);
            key(k, 0);
            chk_all();
            wr(2'h0, 8'h06);
            m_flag = 0;
            chk_all();
        end
        $display("test edge mode done");
        repeat (8) begin
            k = $urandom % 8;
            cfg(8'($urandom), 8'($urandom), 1);
            key(k, 1);
            wr(2'h0, 8'h07);
            chk_all();
            key(k, 0);
            wr(2'h0, 8'h07);
            m_flag = 0;
            chk_all();
        end
        $display("test level mode done");
        cfg(8'hff, 8'h00, 0);
        power_mode <= 2'h1;
        press[3] <= 1'b1;
        // Look just after each edge, once the wake flop has settled
        for (k = 0; k < 10 && wake_req !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        `CHK("wake", 1'b1, wake_req)
        rd(2'h3);
        `CHK("mode", 8'h01, v)
        @(posedge mclk);
        {press, power_mode} <= 10'h000;
        repeat (8) @(posedge mclk);
        wr(2'h0, 8'h06);
        $display("test light stop done");
        power_mode <= 2'h2;
        repeat (4) @(posedge mclk);
        power_mode <= 2'h0;
        repeat (2) @(posedge mclk);
        {m_en, m_pol, m_ie, m_lvl, m_flag} = '0;
        chk_all();
        $display("test deep stop done");
        close_out();
    end
endmodule
bind pinirq_top kpi_asserts #(.NPINS(NPINS)) u_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_mode(power_mode),
    .pin_interrupt_input(pin_interrupt_input), .port_resistor_enable(port_resistor_enable),
    .pad_pullup(pad_pullup), .irq_req(irq_req), .wake_req(wake_req));
